// ===== core/fp_pipe_pkg.sv
// constants, types and helpers shared by the fetch, dispatch and execute control
// What this block does
// - no interlocks; fixed timing, software schedules around result latencies
// - dispatch can issue up to eight parallel instructions every cycle
// - parallel instructions occupy the same phase in the same cycle
// - serial instructions keep a constant phase offset through the pipeline
// - loads and stores present addresses in the same phase
// - every instruction takes four fetch phases then two decode phases
// - fetch packets of eight move through fetch phases as one unit
// - fetch order: address generate, address send, memory wait, packet arrival
// - dispatch splits fetch packets into execute packets of one to eight
// - each execute packet instruction is routed to its functional unit
// - decode phase yields source, destination registers and routing per unit
// - no_operation slots are never routed to a functional unit
// - an execute packet in decode enters the first execute phase next cycle
// - ten execute phases; each instruction class has a fixed phase count
// - multiple execute packets stall earlier stages until the last reaches decode
// - memory not ready holds every phase; results unchanged
package fp_pipe_pkg;
  localparam int NUM_SLOTS    = 8;   // instructions per fetch_packet
  localparam int NUM_UNITS    = 8;   // functional units
  localparam int NUM_EXEC     = 10;  // execute phases
  localparam int INSTR_W      = 32;
  localparam int ADDR_W       = 32;
  localparam int LAT_W        = 4;
  localparam int REG_W        = 5;
  localparam int UNIT_W       = 3;
  localparam int CLASS_W      = 3;
  // instruction field positions
  localparam int PBIT_POS     = 0;   // parallel bit: next slot joins this execute_packet
  localparam int UNIT_LSB     = 1;
  localparam int CLASS_LSB    = 4;
  localparam int SRC1_LSB     = 13;
  localparam int SRC2_LSB     = 18;
  localparam int DST_LSB      = 23;
  // no_operation encoding, parallel bit ignored
  localparam logic [INSTR_W-1:0] NOP_MASK = 32'hffff_fffe;
  localparam logic [INSTR_W-1:0] NOP_CODE = 32'h0000_0000;
  localparam logic [ADDR_W-1:0]  RESET_PC   = 32'h0000_0000;
  localparam logic [ADDR_W-1:0]  PKT_BYTES  = 32'h0000_0020;
  localparam logic [NUM_SLOTS-1:0] ALL_SLOTS = 8'hff;

  typedef enum logic [CLASS_W-1:0] {
    CLS_SINGLE, CLS_TWO, CLS_FOUR, CLS_LOAD, CLS_STORE, CLS_ADDDP, CLS_MULI, CLS_MULDP
  } iclass_t;

  // execute phases used by each class
  function automatic logic [LAT_W-1:0] class_phases(input iclass_t c);
    unique case (c)
      CLS_SINGLE: class_phases = 4'h1;
      CLS_TWO:    class_phases = 4'h2;
      CLS_STORE:  class_phases = 4'h3;
      CLS_FOUR:   class_phases = 4'h4;
      CLS_LOAD:   class_phases = 4'h5;
      CLS_ADDDP:  class_phases = 4'h7;
      CLS_MULI:   class_phases = 4'h9;
      CLS_MULDP:  class_phases = 4'ha;
    endcase
  endfunction : class_phases

  function automatic logic is_nop(input logic [INSTR_W-1:0] i);
    is_nop = (i & NOP_MASK) == NOP_CODE;
  endfunction : is_nop
endpackage : fp_pipe_pkg

// ===== core/ep_if.sv
// one execute_packet as routed onto the functional units
`timescale 1ns/1ns
interface ep_if import fp_pipe_pkg::*; #(parameter int NU = NUM_UNITS);
  logic                          valid;
  logic [NU-1:0]                 unit_mask;
  logic [NU-1:0][INSTR_W-1:0]    instr;
  logic [NU-1:0][LAT_W-1:0]      lat;
  logic [NU-1:0]                 ldst;
  modport producer (output valid, output unit_mask, output instr, output lat, output ldst);
  modport consumer (input valid, input unit_mask, input instr, input lat, input ldst);
endinterface : ep_if

// ===== core/ep_splitter.sv
// carves the next execute_packet out of a fetch_packet and routes it to units
`timescale 1ns/1ns
module ep_splitter import fp_pipe_pkg::*; #(
  parameter int NS = NUM_SLOTS
) (
  // fetch_packet in dispatch_phase
  input  wire logic                       valid,
  input  wire logic [NS-1:0][INSTR_W-1:0] packet,
  input  wire logic [NS-1:0]              pending,
  // this execute_packet
  output      logic [NS-1:0]              slot_mask,
  output      logic                       last,
  ep_if.producer                          ep
);
  logic [UNIT_W-1:0] u;
  logic              closed;

  // packet spans from first pending slot to first clear parallel bit
  always_comb begin
    slot_mask = '0;
    closed    = 1'b0;
    for (int i = 0; i < NS; i++) begin
      if (pending[i] && !closed) begin
        slot_mask[i] = 1'b1;
        if (!packet[i][PBIT_POS]) closed = 1'b1;
      end
    end
    last = (pending & ~slot_mask) == '0;
  end

  // unit conflicts inside a packet are the scheduler's problem, last slot wins
  always_comb begin
    ep.valid     = valid;
    ep.unit_mask = '0;
    ep.instr     = '0;
    ep.lat       = '0;
    ep.ldst      = '0;
    u            = '0;
    for (int i = 0; i < NS; i++) begin
      u = packet[i][UNIT_LSB +: UNIT_W];
      if (valid && slot_mask[i] && !is_nop(packet[i])) begin
        ep.unit_mask[u] = 1'b1;
        ep.instr[u]     = packet[i];
        ep.lat[u]       = class_phases(iclass_t'(packet[i][CLASS_LSB +: CLASS_W]));
        ep.ldst[u]      = iclass_t'(packet[i][CLASS_LSB +: CLASS_W]) inside {CLS_LOAD, CLS_STORE};
      end
    end
  end
endmodule : ep_splitter

// ===== core/exec_phase_track.sv
// tracks instructions per unit through the execute phases
`timescale 1ns/1ns
module exec_phase_track import fp_pipe_pkg::*; #(
  parameter int NP = NUM_EXEC,
  parameter int NU = NUM_UNITS
) (
  // clock and reset
  input  wire logic          core_clk,
  input  wire logic          rst,
  // control
  input  wire logic          hold,
  ep_if.consumer             e1_in,
  // status
  output      logic [NU-1:0] finish_mask,
  output      logic [NU-1:0] e1_ldst,
  output      logic [NU-1:0] e2_ldst,
  output      logic [NU-1:0] e3_ldst
);
  logic [NP-1:0][NU-1:0]            live, next_live;
  logic [NP-1:0][NU-1:0][LAT_W-1:0] lat, next_lat;
  logic [NP-1:0][NU-1:0]            ldst, next_ldst;
  logic [NP-1:0][NU-1:0]            fin;

  // an instruction finishes in the phase equal to its class count
  always_comb begin
    finish_mask = '0;
    for (int k = 0; k < NP; k++) begin
      for (int u = 0; u < NU; u++) begin
        fin[k][u] = live[k][u] && (lat[k][u] == LAT_W'(k + 1));
        finish_mask[u] = finish_mask[u] | fin[k][u];
      end
    end
    e1_ldst = live[0] & ldst[0];
    e2_ldst = live[1] & ldst[1];
    e3_ldst = live[2] & ldst[2];
  end

  // whole rows shift, so parallel work stays in step and serial offsets hold
  always_comb begin
    next_live = live;
    next_lat  = lat;
    next_ldst = ldst;
    if (!hold) begin
      next_live[0] = e1_in.valid ? e1_in.unit_mask : '0;
      next_lat[0]  = e1_in.lat;
      next_ldst[0] = e1_in.ldst;
      for (int k = 1; k < NP; k++) begin
        next_live[k] = live[k-1] & ~fin[k-1];
        next_lat[k]  = lat[k-1];
        next_ldst[k] = ldst[k-1];
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      live <= '0;
      lat  <= '0;
      ldst <= '0;
    end else begin
      live <= next_live;
      lat  <= next_lat;
      ldst <= next_ldst;
    end
  end

  // helper: nothing may linger past its finishing phase
  logic overrun;
  always_comb begin
    overrun = 1'b0;
    for (int k = 0; k < NP; k++)
      for (int u = 0; u < NU; u++)
        if (live[k][u] && lat[k][u] < LAT_W'(k + 1)) overrun = 1'b1;
  end

  a_no_phase_overrun: assert property (@(posedge core_clk) disable iff (rst) !overrun)
    else $error("instruction still live after its last execute phase");
  a_e1_entry: assert property (@(posedge core_clk) disable iff (rst)
    (!hold && e1_in.valid) |=> live[0] == $past(e1_in.unit_mask))
    else $error("decode packet did not enter first execute phase");
  cov_ten_phase: cover property (@(posedge core_clk) disable iff (rst) fin[NP-1] != '0);
endmodule : exec_phase_track

// ===== core/fp_dsp_pipeline_flow.sv
// fetch, dispatch, decode and execute phase control of the vliw pipeline
`timescale 1ns/1ns
module fp_dsp_pipeline_flow import fp_pipe_pkg::*; #(
  parameter int NS = NUM_SLOTS,
  parameter int NU = NUM_UNITS
) (
  // clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  // program memory
  output      logic                       pmem_req,
  output      logic [ADDR_W-1:0]          pmem_addr,
  input  wire logic                       pmem_ready,
  input  wire logic [NS-1:0][INSTR_W-1:0] pmem_rdata,
  // branch redirect into address generation
  input  wire logic                       redirect_valid,
  input  wire logic [ADDR_W-1:0]          redirect_addr,
  // data memory readiness
  input  wire logic                       dmem_ready,
  // decode phase outputs per functional unit
  output      logic                       dc_valid,
  output      logic [NU-1:0]              dc_unit_mask,
  output      logic [NU-1:0][INSTR_W-1:0] dc_instr,
  output      logic [NU-1:0][REG_W-1:0]   dc_src1,
  output      logic [NU-1:0][REG_W-1:0]   dc_src2,
  output      logic [NU-1:0][REG_W-1:0]   dc_dst,
  // execute phase events
  output      logic [NU-1:0]              mem_addr_strobe,
  output      logic [NU-1:0]              unit_retire
);
  // fetch chain state
  logic                       pg_valid, next_pg_valid;
  logic [ADDR_W-1:0]          pc, next_pc;
  logic                       ps_valid, next_ps_valid;
  logic [ADDR_W-1:0]          ps_addr, next_ps_addr;
  logic                       pw_valid, next_pw_valid;
  logic                       pr_valid, next_pr_valid;
  logic [NS-1:0][INSTR_W-1:0] pr_packet, next_pr_packet;
  // dispatch state
  logic                       dp_valid, next_dp_valid;
  logic [NS-1:0][INSTR_W-1:0] dp_packet, next_dp_packet;
  logic [NS-1:0]              dp_pending, next_dp_pending;
  // decode state
  logic                       next_dc_valid;
  logic [NU-1:0]              next_dc_unit_mask;
  logic [NU-1:0][INSTR_W-1:0] next_dc_instr;
  logic [NU-1:0][LAT_W-1:0]   dc_lat, next_dc_lat;
  logic [NU-1:0]              dc_ldst, next_dc_ldst;
  // execute events
  logic [NU-1:0]              next_mem_addr_strobe;
  logic [NU-1:0]              next_unit_retire;
  // control terms
  logic                       mem_stall;
  logic                       dp_hold;
  logic                       advance_fetch;
  logic [NS-1:0]              ep_slots;
  logic                       ep_last;
  logic [NU-1:0]              finish_mask;
  logic [NU-1:0]              e1_ldst, e2_ldst, e3_ldst;

  ep_if #(.NU(NU)) dp_ep ();
  ep_if #(.NU(NU)) e1_ep ();

  ep_splitter #(.NS(NS)) u_splitter (
    .valid     (dp_valid),
    .packet    (dp_packet),
    .pending   (dp_pending),
    .slot_mask (ep_slots),
    .last      (ep_last),
    .ep        (dp_ep)
  );

  exec_phase_track #(.NP(NUM_EXEC), .NU(NU)) u_exec (
    .core_clk    (core_clk),
    .rst         (rst),
    .hold        (mem_stall),
    .e1_in       (e1_ep),
    .finish_mask (finish_mask),
    .e1_ldst     (e1_ldst),
    .e2_ldst     (e2_ldst),
    .e3_ldst     (e3_ldst)
  );

  // decode registers feed the first execute phase directly
  assign e1_ep.valid     = dc_valid;
  assign e1_ep.unit_mask = dc_unit_mask;
  assign e1_ep.instr     = dc_instr;
  assign e1_ep.lat       = dc_lat;
  assign e1_ep.ldst      = dc_ldst;

  // register fields of each routed instruction
  always_comb begin
    for (int u = 0; u < NU; u++) begin
      dc_src1[u] = dc_instr[u][SRC1_LSB +: REG_W];
      dc_src2[u] = dc_instr[u][SRC2_LSB +: REG_W];
      dc_dst[u]  = dc_instr[u][DST_LSB +: REG_W];
    end
  end

  // stall sources; no hazard check on register results at all
  always_comb begin
    mem_stall     = (pw_valid && !pmem_ready) || ((e3_ldst != '0) && !dmem_ready);
    dp_hold       = dp_valid && !ep_last;
    advance_fetch = !mem_stall && !dp_hold;
  end

  // fetch chain: generate, send, wait, arrival, whole packet at once
  always_comb begin
    next_pg_valid   = 1'b1;
    next_pc         = pc;
    next_ps_valid   = ps_valid;
    next_ps_addr    = ps_addr;
    next_pw_valid   = pw_valid;
    next_pr_valid   = pr_valid;
    next_pr_packet  = pr_packet;
    next_dp_valid   = dp_valid;
    next_dp_packet  = dp_packet;
    next_dp_pending = dp_pending;
    if (advance_fetch) begin
      next_pc         = pg_valid ? pc + PKT_BYTES : pc;
      next_ps_valid   = pg_valid;
      next_ps_addr    = pc;
      next_pw_valid   = ps_valid;
      next_pr_valid   = pw_valid;
      next_pr_packet  = pw_valid ? pmem_rdata : pr_packet;
      next_dp_valid   = pr_valid;
      next_dp_packet  = pr_packet;
      next_dp_pending = ALL_SLOTS;
    end else if (!mem_stall) begin
      next_dp_pending = dp_pending & ~ep_slots;
    end
    // redirect lands on the next generated address, even while stalled
    if (redirect_valid) next_pc = redirect_addr;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pg_valid   <= 1'b0;
      pc         <= RESET_PC;
      ps_valid   <= 1'b0;
      ps_addr    <= RESET_PC;
      pw_valid   <= 1'b0;
      pr_valid   <= 1'b0;
      pr_packet  <= '0;
      dp_valid   <= 1'b0;
      dp_packet  <= '0;
      dp_pending <= ALL_SLOTS;
    end else begin
      pg_valid   <= next_pg_valid;
      pc         <= next_pc;
      ps_valid   <= next_ps_valid;
      ps_addr    <= next_ps_addr;
      pw_valid   <= next_pw_valid;
      pr_valid   <= next_pr_valid;
      pr_packet  <= next_pr_packet;
      dp_valid   <= next_dp_valid;
      dp_packet  <= next_dp_packet;
      dp_pending <= next_dp_pending;
    end
  end

  // the address is on the pins for the whole send phase
  assign pmem_req  = ps_valid;
  assign pmem_addr = ps_addr;

  // decode takes one execute_packet per cycle from dispatch
  always_comb begin
    next_dc_valid     = dc_valid;
    next_dc_unit_mask = dc_unit_mask;
    next_dc_instr     = dc_instr;
    next_dc_lat       = dc_lat;
    next_dc_ldst      = dc_ldst;
    if (!mem_stall) begin
      next_dc_valid     = dp_ep.valid;
      next_dc_unit_mask = dp_ep.unit_mask;
      next_dc_instr     = dp_ep.instr;
      next_dc_lat       = dp_ep.lat;
      next_dc_ldst      = dp_ep.ldst;
    end
  end

  // execute events: address strobe mirrors the second execute phase
  always_comb begin
    next_mem_addr_strobe = mem_stall ? mem_addr_strobe : e1_ldst;
    next_unit_retire     = mem_stall ? '0 : finish_mask;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dc_valid        <= 1'b0;
      dc_unit_mask    <= '0;
      dc_instr        <= '0;
      dc_lat          <= '0;
      dc_ldst         <= '0;
      mem_addr_strobe <= '0;
      unit_retire     <= '0;
    end else begin
      dc_valid        <= next_dc_valid;
      dc_unit_mask    <= next_dc_unit_mask;
      dc_instr        <= next_dc_instr;
      dc_lat          <= next_dc_lat;
      dc_ldst         <= next_dc_ldst;
      mem_addr_strobe <= next_mem_addr_strobe;
      unit_retire     <= next_unit_retire;
    end
  end

  // helper: a no_operation routed into decode
  logic nop_routed;
  always_comb begin
    nop_routed = 1'b0;
    for (int u = 0; u < NU; u++)
      if (dc_valid && dc_unit_mask[u] && is_nop(dc_instr[u])) nop_routed = 1'b1;
  end

  a_nop_unrouted: assert property (@(posedge core_clk) disable iff (rst) !nop_routed)
    else $error("no_operation routed to a functional unit");
  a_fetch_lockstep: assert property (@(posedge core_clk) disable iff (rst)
    (advance_fetch && pw_valid) |=> pr_valid && pr_packet == $past(pmem_rdata))
    else $error("packet not captured on leaving the wait phase");
  a_send_order: assert property (@(posedge core_clk) disable iff (rst)
    (advance_fetch && pg_valid) |=> ps_valid && pmem_addr == $past(pc))
    else $error("generated address not sent in following cycle");
  a_split_hold: assert property (@(posedge core_clk) disable iff (rst)
    (dp_hold && !mem_stall) |=> $stable(ps_addr) && $stable(pr_packet) && dp_valid)
    else $error("earlier stages moved during dispatch split");
  a_split_release: assert property (@(posedge core_clk) disable iff (rst)
    (dp_valid && ep_last && !mem_stall) |=> dp_pending == ALL_SLOTS)
    else $error("dispatch not released after last execute packet");
  a_ep_slots: assert property (@(posedge core_clk) disable iff (rst)
    dp_valid |-> ep_slots != '0 && (ep_slots & ~dp_pending) == '0)
    else $error("execute packet empty or outside pending slots");
  a_mem_freeze: assert property (@(posedge core_clk) disable iff (rst)
    mem_stall |=> $stable(dc_instr) && $stable(ps_addr) && $stable(dp_pending) && unit_retire == '0)
    else $error("pipeline moved during memory stall");
  a_decode_step: assert property (@(posedge core_clk) disable iff (rst)
    (!mem_stall && dp_valid) |=> dc_valid ##0 dc_unit_mask == $past(dp_ep.unit_mask))
    else $error("dispatch did not advance into decode");
  a_addr_phase: assert property (@(posedge core_clk) disable iff (rst)
    mem_addr_strobe == e2_ldst)
    else $error("load or store address strobe outside second execute phase");
  a_fetch_serial: assert property (@(posedge core_clk) disable iff (rst)
    (advance_fetch && pg_valid) ##1 advance_fetch [*3] |=> dp_valid)
    else $error("fetch_packet not in dispatch four phases after generate");

  cov_split: cover property (@(posedge core_clk) disable iff (rst) dp_hold [*2] ##1 !dp_hold);
  cov_mem_stall: cover property (@(posedge core_clk) disable iff (rst) mem_stall ##1 !mem_stall);
  cov_full_issue: cover property (@(posedge core_clk) disable iff (rst) dc_unit_mask == '1);
  cov_retire: cover property (@(posedge core_clk) disable iff (rst) unit_retire != '0);
endmodule : fp_dsp_pipeline_flow

// ===== tb/pmem_model.sv
// program memory partner: answers each fetch_packet address from a packet image
`timescale 1ns/1ns
module pmem_model import fp_pipe_pkg::*; (
  // clock and reset
  input  wire logic                              core_clk,
  input  wire logic                              rst,
  // bench control and packet image
  input  wire logic                              slow,
  input  wire logic [NUM_SLOTS-1:0][INSTR_W-1:0] image [16],
  // program memory side
  input  wire logic                              pmem_req,
  input  wire logic [ADDR_W-1:0]                 pmem_addr,
  output      logic                              pmem_ready,
  output      logic [NUM_SLOTS-1:0][INSTR_W-1:0] pmem_rdata
);
  logic [ADDR_W-1:0] prev_addr;
  logic [ADDR_W-1:0] wait_q;
  logic [ADDR_W-1:0] wait_addr;
  logic              prev_req;
  logic [1:0]        cnt;

  // a send phase that moved on shows a new address; held sends keep the old wait
  always_comb begin
    wait_addr = (prev_req && pmem_addr != prev_addr) ? prev_addr : wait_q;
    pmem_ready = !slow || cnt != 2'h0;
    pmem_rdata = rst ? ~image[0] : image[wait_addr[8:5]];
  end

  // remember last send and the packet in wait
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prev_addr <= '0;
      prev_req  <= 1'b0;
      wait_q    <= '0;
      cnt       <= 2'h0;
    end else begin
      prev_addr <= pmem_addr;
      prev_req  <= pmem_req;
      wait_q    <= wait_addr;
      cnt       <= cnt + 2'h1;
    end
  end
endmodule : pmem_model

// ===== tb/testbench.sv
// self-checking bench: packet image, decode scoreboard and execute timing
`timescale 1ns/1ns
module testbench import fp_pipe_pkg::*; ();
  logic                              core_clk = 1'b0;
  logic                              rst = 1'b1;
  logic                              redirect_valid = 1'b0;
  logic                              dmem_ready = 1'b1;
  logic                              slow = 1'b0;
  logic                              timed = 1'b1;
  logic [ADDR_W-1:0]                 redirect_addr = 32'h0000_0000;
  logic                              pmem_req, pmem_ready, dc_valid;
  logic [ADDR_W-1:0]                 pmem_addr;
  logic [NUM_SLOTS-1:0][INSTR_W-1:0] pmem_rdata, image [16];
  logic [NUM_UNITS-1:0]              dc_unit_mask, mem_addr_strobe, unit_retire, em;
  logic [NUM_UNITS-1:0][INSTR_W-1:0] dc_instr, ei;
  logic [NUM_UNITS-1:0][REG_W-1:0]   dc_src1, dc_src2, dc_dst;
  logic [NUM_UNITS-1:0]              exp_mask [$];
  logic [NUM_UNITS-1:0][INSTR_W-1:0] exp_instr [$];
  int                                rq [NUM_UNITS][$];
  int                                sq [NUM_UNITS][$];
  int                                ph [8] = '{1, 2, 4, 5, 3, 7, 9, 10};
  int                                miscompares = 0, check_count = 0, cyc = 0, seed = 94, last_dc = -1, rel = 0;
  logic                              held = 1'b0, stalled = 1'b0, e3 = 1'b0, strb_seen = 1'b0;

  always #4 core_clk = ~core_clk;

  fp_dsp_pipeline_flow uut (.core_clk(core_clk), .rst(rst), .pmem_req(pmem_req), .pmem_addr(pmem_addr),
    .pmem_ready(pmem_ready), .pmem_rdata(pmem_rdata), .redirect_valid(redirect_valid),
    .redirect_addr(redirect_addr), .dmem_ready(dmem_ready), .dc_valid(dc_valid), .dc_unit_mask(dc_unit_mask),
    .dc_instr(dc_instr), .dc_src1(dc_src1), .dc_src2(dc_src2), .dc_dst(dc_dst),
    .mem_addr_strobe(mem_addr_strobe), .unit_retire(unit_retire));

  pmem_model mem (.core_clk(core_clk), .rst(rst), .slow(slow), .image(image), .pmem_req(pmem_req),
    .pmem_addr(pmem_addr), .pmem_ready(pmem_ready), .pmem_rdata(pmem_rdata));

  task automatic print_verdict();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  task automatic chk_vec(input logic [383:0] got, input logic [383:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_vec

  task automatic chk_cyc(input int got, input int exp);
    check_count++;
    if (got != exp) begin
      miscompares++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_cyc

  // unit u always carries class u, so each unit retires in issue order
  function automatic logic [INSTR_W-1:0] make_instr(input int u);
    logic [31:0] r;
    r = $random(seed);
    if (r[31:29] == 3'h0) return {31'h0, r[0]};
    return {1'b1, r[30:7], 3'(u), 3'(u), r[0]};
  endfunction : make_instr

  function automatic logic [383:0] dec_vec(input logic [7:0] m, input logic [7:0][31:0] v);
    logic [7:0][4:0] a, b, d;
    for (int u = 0; u < 8; u++) begin
      a[u] = v[u][17:13];
      b[u] = v[u][22:18];
      d[u] = v[u][27:23];
    end
    return {m, v, a, b, d};
  endfunction : dec_vec

  // split one packet into its execute_packets, skipping no_operation slots
  task automatic note_packet(input int p);
    logic [7:0]       m;
    logic [7:0][31:0] v;
    m = '0;
    v = '0;
    for (int s = 0; s < NUM_SLOTS; s++) begin
      if (image[p][s][31:1] != 31'h0) begin
        m[s] = 1'b1;
        v[s] = image[p][s];
      end
      if (!image[p][s][0] || s == NUM_SLOTS - 1) begin
        exp_mask.push_back(m);
        exp_instr.push_back(v);
        m = '0;
        v = '0;
      end
    end
  endtask : note_packet

  // watcher: decode stream, decode spacing, strobe and retire moments
  always @(posedge core_clk) begin
    cyc++;
    if (cyc > 4000) begin
      miscompares++;
      print_verdict();
    end
    // a stalled cycle leaves decode as it was, so the next sample is a repeat
    held = stalled;
    e3 = (strb_seen && !stalled) || (e3 && stalled); // load or store in its data access phase
    stalled = !rst && (pmem_ready === 1'b0 || (e3 && dmem_ready === 1'b0));
    strb_seen = mem_addr_strobe != '0;
    if (!rst && dc_valid && !held && exp_mask.size() > 0) begin
      em = exp_mask.pop_front();
      ei = exp_instr.pop_front();
      chk_vec({dc_unit_mask, dc_instr, dc_src1, dc_src2, dc_dst}, dec_vec(em, ei));
      if (last_dc < 0) chk_cyc(cyc, rel + 7);
      else if (timed) chk_cyc(cyc, last_dc + 1);
      last_dc = cyc;
      for (int u = 0; u < NUM_UNITS; u++) begin
        if (em[u]) rq[u].push_back(cyc + ph[u] + 1);
        if (em[u] && (u == 3 || u == 4)) sq[u].push_back(cyc + 2);
      end
    end
    for (int u = 0; u < NUM_UNITS; u++) begin
      if (unit_retire[u] === 1'b1 && rq[u].size() > 0 && timed) chk_cyc(cyc, rq[u].pop_front());
      if (mem_addr_strobe[u] === 1'b1 && sq[u].size() > 0 && timed) chk_cyc(cyc, sq[u].pop_front());
    end
  end

  // main sequence: fast run, stalled run, then a redirect
  initial begin
    for (int p = 0; p < 16; p++) begin
      for (int s = 0; s < NUM_SLOTS; s++) image[p][s] = make_instr(s);
    end
    for (int n = 0; n < 48; n++) note_packet(n % 16);
    repeat (8) @(negedge core_clk);
    chk_vec(384'({pmem_req, dc_valid, pmem_addr}), '0);
    rst = 1'b0;
    rel = cyc;
    repeat (60) @(negedge core_clk);
    // timing checks stop here: stalls stretch every phase
    slow = 1'b1;
    timed = 1'b0;
    for (int i = 0; i < 2000 && exp_mask.size() > 0; i++) begin
      @(negedge core_clk);
      dmem_ready = ($random(seed) & 3) != 0;
    end
    chk_cyc(exp_mask.size(), 0);
    slow = 1'b0;
    dmem_ready = 1'b1;
    redirect_valid = 1'b1;
    redirect_addr = 32'h0000_01e0;
    @(negedge core_clk);
    redirect_valid = 1'b0;
    for (int i = 0; i < 12 && !(pmem_req === 1'b1 && pmem_addr === 32'h0000_01e0); i++) @(negedge core_clk);
    chk_vec(384'(pmem_addr), 384'h1e0);
    print_verdict();
  end
endmodule : testbench
